// *** design/aio_sequencer.v ***
/*
  aio_sequencer.v: controller core of a 24-in, 8-out analog i/o card:
  bank capture after the frame tick, setpoint events with time stamps,
  8 pwm current outputs with readback fault checks, fault lamp blinker,
  APB register slave and a masked level interrupt.
  Assumes frame_tick, adc data and readback come from outside the clock
  domain; a single 10 MHz core clock.
*/
// Overview of operation
// - bank one, channels 1-12, captured at 1.8 ms
// - bank two, channels 13-24, captured at 3.7 ms
// - stamp two low, two high crossings, 5 ms
// - momentary and latched per setpoint, both stamped
// - eight pwm outputs, ~4.9 kHz, 11-bit duty
// - each output disables on its own
// - 8-bit current readback flags low current
// - fault lamp on at system reset
// - lamp steady per ctrl lamp bit on pass, blinking else
// - blink 1 watchdog, 2 int ram, 3 ext ram
// - blink 4 exception, 5 dpram, 6 nvm
// - blink 7 on comms watchdog timeout
// - blink 8 nvm corrected, hold until reset or a zero write with ctrl resume set
// - blink 9 on missing converter interrupt
// - microcontroller fault shuts all outputs
`include "aio_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module aio_sequencer #(
  parameter integer BLINK_CYC = `AIO_BLINK_CYC,
  parameter integer PAUSE_CYC = `AIO_PAUSE_CYC,
  parameter integer BANK_A_CYC = `AIO_BANK_A_CYC,
  parameter integer BANK_B_CYC = `AIO_BANK_B_CYC,
  parameter integer TSTAMP_CYC = `AIO_TSTAMP_CYC
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        frame_tick,
  input  wire [15:0] adc_data,
  output reg  [4:0]  adc_chan,
  input  wire [63:0] rdbk_current,
  output reg  [7:0]  pwm_out,
  output reg         fault_lamp,
  output reg         irq
);

  // input synchronisers: three stages, a tick change counts when 2 and 3 agree
  reg [2:0]  tick_s;
  reg        tick_q;
  reg [15:0] adc_s1, adc_s2, adc_s3;
  reg [63:0] rb_s1, rb_s2, rb_s3;
  wire tick_ok  = (tick_s[1] == tick_s[2]) ? tick_s[2] : tick_q;
  wire tick_rise = tick_ok & ~tick_q;

  // software state
  reg [31:0] ctrl;
  reg [3:0]  fault_code;
  reg [7:0]  out_en;
  reg [7:0]  rdbk_lim;
  reg [15:0] sp_lo1, sp_lo2, sp_hi1, sp_hi2;
  reg [3:0]  int_stat, int_mask;
  reg        code_held;
  reg [87:0] duty_flat;

  // bank sampling and time base
  reg [15:0] frame_cnt;
  reg        frame_run;
  reg [15:0] ts_div;
  reg [15:0] tstamp;
  reg [4:0]  cap_idx;
  reg        cap_busy;
  reg [1:0]  cap_wait;
  reg [15:0] bank_a_ts, bank_b_ts;
  reg [15:0] sample [0:23];
  reg [3:0]  evt_mom [0:23];
  reg [3:0]  evt_lat [0:23];
  reg [15:0] evt_ts  [0:23];
  reg [7:0]  out_fault;
  integer    i;

  wire bus_wr = psel & penable & pwrite & ~pready;
  wire bus_rd = psel & penable & ~pwrite & ~pready;
  wire uc_fault = ctrl[`AIO_CTRL_UC_FAULT];

  // sync chains, frozen with the clock enable
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_s <= 3'h0;
      tick_q <= 1'b0;
      adc_s1 <= 16'h0000;
      adc_s2 <= 16'h0000;
      adc_s3 <= 16'h0000;
      rb_s1 <= 64'h0;
      rb_s2 <= 64'h0;
      rb_s3 <= 64'h0;
    end
    else if (clk_en)
    begin
      tick_s <= {tick_s[1:0], frame_tick};
      tick_q <= tick_ok;
      adc_s1 <= adc_data;
      adc_s2 <= adc_s1;
      adc_s3 <= adc_s2;
      rb_s1 <= rdbk_current;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
    end
  end

  // frame sequencer: bank a then bank b, one channel per cycle
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_cnt <= 16'h0000;
      frame_run <= 1'b0;
      cap_idx <= 5'h00;
      cap_busy <= 1'b0;
      cap_wait <= 2'h0;
      adc_chan <= 5'h00;
      ts_div <= 16'h0000;
      tstamp <= 16'h0000;
      bank_a_ts <= 16'h0000;
      bank_b_ts <= 16'h0000;
      for (i = 0; i < 24; i = i + 1)
      begin
        sample[i] <= 16'h0000;
        evt_mom[i] <= 4'h0;
        evt_lat[i] <= 4'h0;
        evt_ts[i] <= 16'h0000;
      end
    end
    else if (clk_en)
    begin
      // latch clear first, so a capture in the same cycle wins
      if (bus_wr && paddr[11:7] == 5'h01)
        for (i = 0; i < 24; i = i + 1)
          if (paddr[6:2] == i[4:0] && pwdata[0])
            evt_lat[i] <= 4'h0;
      // 5 ms stamp tick
      if (ts_div == TSTAMP_CYC[15:0] - 16'h0001)
      begin
        ts_div <= 16'h0000;
        tstamp <= tstamp + 16'h0001;
      end
      else
        ts_div <= ts_div + 16'h0001;
      if (tick_rise)
      begin
        frame_cnt <= 16'h0000;
        frame_run <= 1'b1;
      end
      else if (frame_run)
        frame_cnt <= frame_cnt + 16'h0001;
      if (frame_run && frame_cnt == BANK_A_CYC[15:0] - 16'h0001)
      begin
        cap_idx <= 5'h00;
        adc_chan <= 5'h00;
        cap_wait <= 2'h3;
        cap_busy <= 1'b1;
        bank_a_ts <= tstamp;
      end
      else if (frame_run && frame_cnt == BANK_B_CYC[15:0] - 16'h0001)
      begin
        cap_idx <= 5'h0C;
        adc_chan <= 5'h0C;
        cap_wait <= 2'h3;
        cap_busy <= 1'b1;
        bank_b_ts <= tstamp;
        frame_run <= 1'b0;
      end
      else if (cap_busy)
      begin
        // channel select leads the capture by the 3-stage sync delay
        if (adc_chan != 5'h0B && adc_chan != 5'h17)
          adc_chan <= adc_chan + 5'h01;
        if (cap_wait != 2'h0)
          cap_wait <= cap_wait - 2'h1;
        else
        begin
          sample[cap_idx] <= adc_s3;
          // momentary event bits: lo1, lo2, hi1, hi2
          evt_mom[cap_idx] <= {adc_s3 > sp_hi2, adc_s3 > sp_hi1,
                               adc_s3 < sp_lo2, adc_s3 < sp_lo1};
          evt_lat[cap_idx] <= evt_lat[cap_idx] |
                              {adc_s3 > sp_hi2, adc_s3 > sp_hi1,
                               adc_s3 < sp_lo2, adc_s3 < sp_lo1};
          if ({adc_s3 > sp_hi2, adc_s3 > sp_hi1, adc_s3 < sp_lo2,
               adc_s3 < sp_lo1} != evt_mom[cap_idx])
            evt_ts[cap_idx] <= tstamp;
          cap_idx <= cap_idx + 5'h01;
          if (cap_idx == 5'h0B || cap_idx == 5'h17)
            cap_busy <= 1'b0;
        end
      end
    end
  end

  // pwm: 11-bit ramp, free running near 4.9 kHz
  reg [10:0] pwm_cnt;
  reg [7:0]  pwm_div;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_cnt <= 11'h000;
      pwm_div <= 8'h00;
      pwm_out <= 8'h00;
      out_fault <= 8'h00;
    end
    else if (clk_en)
    begin
      // step rate clamps at one cycle; 10 MHz gives ~4.9 kHz
      if (pwm_div >= 8'h00 + `AIO_PWM_STEP_CYC)
      begin
        pwm_div <= 8'h00;
        pwm_cnt <= pwm_cnt + 11'h001;
      end
      else
        pwm_div <= pwm_div + 8'h01;
      for (i = 0; i < 8; i = i + 1)
      begin
        // per-channel enable, global shutdown on micro fault
        pwm_out[i] <= out_en[i] & ~uc_fault &
                      (pwm_cnt < duty_flat[i*11 +: 11]);
        // flag current below rdbk_lim while enabled with nonzero duty
        if (out_en[i] && duty_flat[i*11 +: 11] != 11'h000 &&
            rb_s3[i*8 +: 8] < rdbk_lim)
          out_fault[i] <= 1'b1;
        else if (bus_wr && paddr == `AIO_FAULT_OFF && pwdata[i])
          out_fault[i] <= 1'b0;
      end
    end
  end

  // fault lamp: code 0 steady per ctrl, else n blinks then dark pause
  reg [3:0]  blink_n;
  reg [23:0] lamp_cnt;
  reg        lamp_ph;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_lamp <= 1'b1;
      blink_n <= 4'h0;
      lamp_cnt <= 24'h000000;
      lamp_ph <= 1'b0;
    end
    else if (clk_en)
    begin
      if (fault_code == 4'h0)
      begin
        fault_lamp <= ctrl[`AIO_CTRL_LAMP];
        blink_n <= 4'h0;
        lamp_cnt <= 24'h000000;
        lamp_ph <= 1'b0;
      end
      else if (blink_n >= fault_code)
      begin
        fault_lamp <= 1'b0;
        if (lamp_cnt >= PAUSE_CYC[23:0] - 24'h000001)
        begin
          lamp_cnt <= 24'h000000;
          blink_n <= 4'h0;
        end
        else
          lamp_cnt <= lamp_cnt + 24'h000001;
      end
      // >= so a code change mid-pause cannot strand the counter
      else if (lamp_cnt >= BLINK_CYC[23:0] - 24'h000001)
      begin
        lamp_cnt <= 24'h000000;
        lamp_ph <= ~lamp_ph;
        fault_lamp <= ~lamp_ph;
        if (lamp_ph)
          blink_n <= blink_n + 4'h1;
      end
      else
      begin
        lamp_cnt <= lamp_cnt + 24'h000001;
        fault_lamp <= lamp_ph; // a group opens dark, never stretched on
      end
    end
  end

  // APB slave, one wait state; interrupt sticky bits, set beats clear
  wire [3:0] int_set = {|out_fault, |{evt_mom[0], evt_mom[12]},
    cap_busy && cap_idx == 5'h17, cap_busy && cap_idx == 5'h0B};
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `AIO_CTRL_RST;
      fault_code <= 4'h0;
      code_held <= 1'b0;
      out_en <= `AIO_OUT_EN_RST;
      rdbk_lim <= `AIO_RDBK_LIM_RST;
      sp_lo1 <= 16'h0000;
      sp_lo2 <= 16'h0000;
      sp_hi1 <= 16'hFFFF;
      sp_hi2 <= 16'hFFFF;
      int_stat <= 4'h0;
      int_mask <= 4'h0;
      duty_flat <= 88'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (bus_wr)
        case (paddr)
          `AIO_CTRL_OFF: ctrl <= {29'h0, pwdata[2:0]};
          `AIO_INT_STAT_OFF: int_stat <= int_set | (int_stat & ~pwdata[3:0]);
          `AIO_INT_MASK_OFF: int_mask <= pwdata[3:0];
          `AIO_FAULT_CODE_OFF:
            if (!code_held || pwdata[3:0] == 4'h0 && ctrl[2])
            begin
              fault_code <= pwdata[3:0];
              code_held <= (pwdata[3:0] == 4'h8);
            end
          `AIO_OUT_EN_OFF: out_en <= pwdata[7:0];
          `AIO_SETPT_OFF: {sp_hi1, sp_lo1} <= pwdata;
          `AIO_SETPT_OFF + 12'h100: {sp_hi2, sp_lo2} <= pwdata;
          `AIO_RDBK_LIM_OFF: rdbk_lim <= pwdata[7:0];
          default:
            if (paddr[11:5] == 7'h02)
              duty_flat[paddr[4:2]*11 +: 11] <= pwdata[10:0];
        endcase
      if (!(bus_wr && paddr == `AIO_INT_STAT_OFF))
        int_stat <= int_stat | int_set;
      irq <= |(int_stat & int_mask);
      if (bus_rd)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `AIO_CTRL_OFF: prdata <= ctrl;
          `AIO_STATUS_OFF: prdata <= {23'h0, code_held, out_fault};
          `AIO_INT_STAT_OFF: prdata <= {28'h0, int_stat};
          `AIO_INT_MASK_OFF: prdata <= {28'h0, int_mask};
          `AIO_FAULT_CODE_OFF: prdata <= {28'h0, fault_code};
          `AIO_OUT_EN_OFF: prdata <= {24'h0, out_en};
          `AIO_FAULT_OFF: prdata <= {24'h0, out_fault};
          `AIO_SETPT_OFF: prdata <= {sp_hi1, sp_lo1};
          `AIO_SETPT_OFF + 12'h100: prdata <= {sp_hi2, sp_lo2};
          `AIO_TSTAMP_OFF: prdata <= {16'h0, tstamp};
          `AIO_RDBK_LIM_OFF: prdata <= {24'h0, rdbk_lim};
          `AIO_BANK_A_OFF: prdata <= {16'h0, bank_a_ts};
          `AIO_BANK_B_OFF: prdata <= {16'h0, bank_b_ts};
          default:
            if (paddr[11:5] == 7'h02)
              prdata <= {21'h0, duty_flat[paddr[4:2]*11 +: 11]};
            else if (paddr[11:7] == 5'h01 && paddr[6:2] < 5'h18)
              prdata <= {evt_ts[paddr[6:2]], 8'h0,
                         evt_lat[paddr[6:2]], evt_mom[paddr[6:2]]};
            else if (paddr[11:8] == 4'h2 && paddr[6:2] < 5'h18)
              prdata <= {16'h0, sample[paddr[6:2]]};
            else
              pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** design/aio_regs.vh ***
/*
  aio_regs.vh: register offsets, field positions, reset values and timing
  counts for the analog i/o sequencer and fault lamp controller.
  Assumes a 10 MHz core clock and word-aligned APB byte addresses.
*/
`ifndef AIO_REGS_VH
`define AIO_REGS_VH

// register byte offsets
`define AIO_CTRL_OFF        12'h000
`define AIO_STATUS_OFF      12'h004
`define AIO_INT_STAT_OFF    12'h008
`define AIO_INT_MASK_OFF    12'h00C
`define AIO_FAULT_CODE_OFF  12'h010
`define AIO_OUT_EN_OFF      12'h014
`define AIO_FAULT_OFF       12'h018
`define AIO_SETPT_OFF       12'h01C
`define AIO_TSTAMP_OFF      12'h020
`define AIO_DUTY_BASE_OFF   12'h040
`define AIO_RDBK_LIM_OFF    12'h060
`define AIO_EVT_BASE_OFF    12'h080
`define AIO_BANK_A_OFF      12'h0E0
`define AIO_BANK_B_OFF      12'h0E4

// control field positions
`define AIO_CTRL_LAMP       0
`define AIO_CTRL_UC_FAULT   1
`define AIO_CTRL_RESUME     2

// interrupt status bits
`define AIO_INT_BANK_A      0
`define AIO_INT_BANK_B      1
`define AIO_INT_EVENT       2
`define AIO_INT_OUT_FAULT   3

// reset values
`define AIO_CTRL_RST        32'h00000001
`define AIO_OUT_EN_RST      8'hFF
`define AIO_RDBK_LIM_RST    8'h10

// timing in the unit printed, and the clock rate
`define AIO_CLK_HZ          10000000
`define AIO_BANK_A_US       1800
`define AIO_BANK_B_US       3700
`define AIO_TSTAMP_US       5000
`define AIO_PWM_HZ          6140
`define AIO_BANK_A_CYC      ((`AIO_BANK_A_US * (`AIO_CLK_HZ / 1000000)))
`define AIO_BANK_B_CYC      ((`AIO_BANK_B_US * (`AIO_CLK_HZ / 1000000)))
`define AIO_TSTAMP_CYC      ((`AIO_TSTAMP_US * (`AIO_CLK_HZ / 1000000)))
`define AIO_PWM_STEP_CYC    (`AIO_CLK_HZ / (`AIO_PWM_HZ * 2048))
`define AIO_BLINK_CYC       2000000
`define AIO_PAUSE_CYC       8000000

`endif

// *** testbench/aio_seq_sva.sv ***
/* aio_seq_sva.sv: port assertions for aio_sequencer (apb timing, lamp,
   output shutdown, blink spacing).
   Assumes an apb master that holds each request until pready. */
`include "aio_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module aio_seq_sva #(
  parameter integer BLINK_CYC = 20,
  parameter integer PAUSE_CYC = 80
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pwm_out,
  input wire logic        fault_lamp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire        wr = psel && penable && pready && pwrite;
  logic [7:0] en_q;
  logic [1:0] since;
  logic [3:0] code_q;
  int         on_run;
  int         off_run;
  // shadow of enables and fault code; lamp run lengths
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 8'hFF;
      since <= 2'd0;
      code_q <= 4'h0;
      on_run <= 0;
      off_run <= 0;
    end
    else
    begin
      if (wr && paddr == `AIO_OUT_EN_OFF)
      begin
        en_q <= pwdata[7:0];
        since <= 2'd0;
      end
      else if (since != 2'd3)
        since <= since + 2'd1;
      if (wr && paddr == `AIO_FAULT_CODE_OFF)
        code_q <= pwdata[3:0];
      on_run <= (wr && paddr == `AIO_FAULT_CODE_OFF) ? 0 :
                (fault_lamp ? on_run + 1 : 0);
      off_run <= (wr && paddr == `AIO_FAULT_CODE_OFF) ? 0 :
                 (fault_lamp ? 0 : off_run + 1);
    end
  end
  sequence kill_wr;
    wr && paddr == `AIO_CTRL_OFF && pwdata[`AIO_CTRL_UC_FAULT];
  endsequence
  sequence all_dark;
    (pwm_out == 8'h00) [*4];
  endsequence
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  lamp_reset_a: assert property ($rose(rst_n) |-> fault_lamp)
    else $error("lamp dark at reset");
  micro_kill_a: assert property (kill_wr |-> ##2 all_dark)
    else $error("outputs live after micro fault");
  out_disable_a: assert property (since == 2'd3 |->
    (pwm_out & ~en_q) == 8'h00) else $error("disabled output drives");
  blink_on_a: assert property (code_q != 4'h0 |->
    on_run <= BLINK_CYC + 2) else $error("blink too long");
  blink_gap_a: assert property (code_q != 4'h0 |->
    off_run <= PAUSE_CYC + BLINK_CYC + 2) else $error("lamp stuck dark");
endmodule
bind aio_sequencer aio_seq_sva #(.BLINK_CYC(BLINK_CYC), .PAUSE_CYC(PAUSE_CYC))
  aio_seq_sva_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .pwm_out, .fault_lamp);
`default_nettype wire

// *** testbench/aio_front_model.sv ***
/* aio_front_model.sv: analog front end model, converter and readback.
   Assumes the sequencer selects the channel on adc_chan. */
`timescale 1ns/1ps
`default_nettype none
module aio_front_model (
  input  wire logic [4:0]  adc_chan,
  input  wire logic [7:0]  low_mask,
  output logic      [15:0] adc_data,
  output logic      [63:0] rdbk_current
);
  // sample carries its channel so a wrong slot shows up
  assign adc_data = {8'hA5, 3'h0, adc_chan};
  // mid-scale loop current; a set mask bit models an open loop
  always_comb
  begin
    for (int k = 0; k < 8; k++)
      rdbk_current[8*k +: 8] = low_mask[k] ? 8'h00 : 8'h80;
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
/* testbench.sv: apb driven checks of the analog i/o sequencer.
   Assumes shortened timing parameters and the front end model. */
`include "aio_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, frame_tick, err, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, t0;
  logic [7:0]  low_mask, seen;
  wire  [31:0] prdata;
  wire         pready, pslverr, fault_lamp, irq;
  wire  [4:0]  adc_chan;
  wire  [15:0] adc_data;
  wire  [63:0] rdbk_current;
  wire  [7:0]  pwm_out;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n;
  int          codes[9] = '{1, 2, 3, 4, 5, 6, 7, 9, 8};
  always #50 core_clk = ~core_clk;
  aio_sequencer #(.BLINK_CYC(20), .PAUSE_CYC(80), .BANK_A_CYC(18),
    .BANK_B_CYC(37), .TSTAMP_CYC(50)) aio_sequencer_i (.core_clk, .rst_n,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_tick, .adc_data, .adc_chan, .rdbk_current,
    .pwm_out, .fault_lamp, .irq);
  aio_front_model aio_front_model_i (.adc_chan, .low_mask, .adc_data,
    .rdbk_current);
  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, then an idle cycle so requests never collide
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++t < 20);
    if (t >= 20)
      bad_count++; // no answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(string what, logic [11:0] a, logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    check(what, rd & m, exp);
  endtask
  // count one blink group, starting from inside a dark pause
  task automatic count_blinks(output int cnt);
    int dark, t;
    logic prev;
    dark = 0;
    t = 0;
    cnt = 0;
    prev = 1'b0;
    while (dark < 50 && t < 2000)
    begin
      @(posedge core_clk);
      t++;
      dark = fault_lamp ? 0 : dark + 1;
    end
    dark = 0;
    while ((cnt == 0 || dark < 50) && t < 4000)
    begin
      @(posedge core_clk);
      t++;
      if (fault_lamp && !prev)
        cnt++;
      prev = fault_lamp;
      dark = fault_lamp ? 0 : dark + 1;
    end
  endtask
  // watchdog: the whole run needs well under 30000 cycles
  initial
  begin
    #3000000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    {psel, penable, pwrite, frame_tick, paddr, pwdata, low_mask} = '0;
    clk_en = 1'b1;
    repeat (12) @(posedge core_clk);
    check("lamp in reset", {31'h0, fault_lamp}, 32'h1);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdc("ctrl", `AIO_CTRL_OFF, 32'hFFFFFFFF, `AIO_CTRL_RST);
    rdc("out_en", `AIO_OUT_EN_OFF, 32'hFF, 32'hFF);
    rdc("rdbk_lim", `AIO_RDBK_LIM_OFF, 32'hFF, 32'h10);
    apb(1'b0, 12'h3F0, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, `AIO_INT_MASK_OFF, 32'h0);
    frame_tick <= 1'b1;
    repeat (44) @(posedge core_clk);
    rdc("bank a only", `AIO_INT_STAT_OFF, 32'h3, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `AIO_INT_MASK_OFF, 32'h1);
    repeat (2) @(posedge core_clk);
    check("irq open", {31'h0, irq}, 32'h1);
    repeat (10) @(posedge core_clk);
    rdc("both banks", `AIO_INT_STAT_OFF, 32'h3, 32'h3);
    apb(1'b1, `AIO_INT_STAT_OFF, 32'h3);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc("sample ch1", 12'h200, 32'hFFFFFFFF, 32'h0000A500);
    rdc("sample ch2", 12'h204, 32'hFFFFFFFF, 32'h0000A501);
    rdc("sample ch13", 12'h230, 32'hFFFFFFFF, 32'h0000A50C);
    rdc("sample ch24", 12'h25C, 32'hFFFFFFFF, 32'h0000A517);
    frame_tick <= 1'b0;
    apb(1'b1, `AIO_OUT_EN_OFF, 32'hFD);
    for (int k = 0; k < 3; k++)
      apb(1'b1, `AIO_DUTY_BASE_OFF + 12'(4 * k), 32'h7FF);
    low_mask <= 8'h04;
    seen = 8'h00;
    repeat (200) @(posedge core_clk) seen |= pwm_out;
    check("pwm driven", {24'h0, seen & 8'h03}, 32'h1);
    rdc("out fault", `AIO_FAULT_OFF, 32'hFF, 32'h4);
    rdc("fault int", `AIO_INT_STAT_OFF, 32'h8, 32'h8);
    apb(1'b1, `AIO_CTRL_OFF, 32'h3);
    repeat (4) @(posedge core_clk);
    check("micro fault", {24'h0, pwm_out}, 32'h0);
    apb(1'b1, `AIO_CTRL_OFF, 32'h1);
    // one more frame with low setpoint 0xA580, above all samples
    apb(1'b1, `AIO_SETPT_OFF, 32'hFFFFA580);
    frame_tick <= 1'b1;
    repeat (70) @(posedge core_clk);
    rdc("event ch1", `AIO_EVT_BASE_OFF, 32'hFF, 32'h11);
    apb(1'b1, `AIO_EVT_BASE_OFF, 32'h1);
    rdc("latch clear", `AIO_EVT_BASE_OFF, 32'hFF, 32'h01);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, `AIO_FAULT_CODE_OFF, 32'(codes[i]));
      count_blinks(n);
      check("blinks", 32'(n), 32'(codes[i]));
    end
    apb(1'b1, `AIO_FAULT_CODE_OFF, 32'h0);
    count_blinks(n);
    check("code 8 held", 32'(n), 32'h8);
    apb(1'b1, `AIO_CTRL_OFF, 32'h4);
    apb(1'b1, `AIO_FAULT_CODE_OFF, 32'h0);
    repeat (3) @(posedge core_clk);
    check("lamp off on pass", {31'h0, fault_lamp}, 32'h0);
    // stamp counter must stop while the clock enable is low
    apb(1'b0, `AIO_TSTAMP_OFF, 32'h0);
    t0 = rd;
    clk_en <= 1'b0;
    repeat (200) @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, `AIO_TSTAMP_OFF, 32'h0);
    check("clk_en freeze", {31'h0, (rd - t0) < 32'h2}, 32'h1);
    repeat (100) @(posedge core_clk);
    apb(1'b0, `AIO_TSTAMP_OFF, 32'h0);
    check("tstamp runs", {31'h0, (rd - t0) >= 32'h2}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("lamp on reset", {31'h0, fault_lamp}, 32'h1);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    complete_run();
  end
endmodule
`default_nettype wire
